// File: miu_pkg.sv
// constants for the metering interrupt unit
package miu_pkg;
   localparam int FLAG_W = 20;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_MASK  = 6'h18;
   localparam logic [5:0] IDX_FLAGS = 6'h19;
   localparam logic [5:0] IDX_CLR   = 6'h1A;
   localparam logic [5:0] IDX_COMP  = 6'h20;
   localparam logic [5:0] IDX_OPM   = 6'h21;
   // flag positions
   localparam int F_AE  = 0;
   localparam int F_RE  = 1;
   localparam int F_VA  = 2;
   localparam int F_SAG = 3;
   localparam int F_ZTO = 6;
   localparam int F_ZX  = 9;
   localparam int F_LC  = 12;
   localparam int F_SWR = 13;
   localparam int F_PKV = 14;
   localparam int F_PKI = 15;
   localparam int F_WF  = 16;
   localparam int F_APR = 17;
   localparam int F_RPR = 18;
   localparam int F_SEQ = 19;
   // reset values, reserved mask bit, field positions and response codes
   localparam logic [19:0] FLAGS_RST = 20'h02000;
   localparam logic [19:0] MASK_RSV  = 20'h02000;
   localparam logic [7:0]  COMP_RST  = 8'h1C;
   localparam int COMP_SEL_LSB = 2;
   localparam int OPM_SWR_BIT  = 6;
   localparam int OPM_PIN_BIT  = 7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // software reset settle time
   localparam int SWR_TIME_NS  = 166000;
   localparam int CLK_NS       = 40;
   localparam int SWR_CYC      = (SWR_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int SWR_CNT_W    = 13;
endpackage : miu_pkg

// File: miu_top.sv
// interrupt status, mask and request logic with an AXI4-Lite register slave
`timescale 1ns/1ps

// Notes on behaviour
// - an enabled event drives the interrupt request pin low.
// - reading the clearing register releases the request pin.
// - each event sets its flag; flags stay set until cleared.
// - reading the clearing register returns flags, then clears them all.
// - bit 0 flags a change of bit 14 in any active energy accumulator.
// - bit 1 flags a change of bit 14 in any reactive energy accumulator.
// - bit 2 flags a rise of bit 15 in any apparent energy accumulator.
// - bits 3 to 5 flag voltage sag on phases A, B, C.
// - bits 6 to 8 flag crossing timeout on phases A, B, C.
// - bits 9 to 11 flag voltage zero crossing on phases A, B, C.
// - bit 12 flags end of half line cycle accumulation.
// - bit 14 flags voltage above its peak threshold.
// - bit 15 flags current above its peak threshold.
// - bit 16 flags a new waveform sample.
// - bit 17 flags active power sign change on a selected phase.
// - bit 18 flags reactive power sign change on a selected phase.
// - bit 19 flags phase A crossing followed next by phase B.
// - bit 13 sets 166 us after software reset, held until clearing read.
// - computation mode bits 2 to 4 select phases for sign events.
module miu_top
   import miu_pkg::*;
#(
   parameter int SWR_CYCLES = SWR_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [2:0]  active_energy_b14,
   input  wire logic [2:0]  reactive_energy_b14,
   input  wire logic [2:0]  apparent_energy_b15,
   input  wire logic [2:0]  sag_event,
   input  wire logic [2:0]  crossing_timeout_event,
   input  wire logic [2:0]  crossing_event,
   input  wire logic        line_cycle_done,
   input  wire logic        voltage_peak_exceeded,
   input  wire logic        current_peak_exceeded,
   input  wire logic        waveform_sample_ready,
   input  wire logic [2:0]  active_power_sign,
   input  wire logic [2:0]  reactive_power_sign,
   input  wire logic        irq_n_i,
   output logic             irq_n_o,
   output logic             irq_n_oe
);

   typedef struct packed {
      logic                 aw_have;
      logic [5:0]           aw_idx;
      logic                 w_have;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [19:0]          mask;
      logic [19:0]          flags;
      logic [7:0]           comp;
      logic                 swr_busy;
      logic [SWR_CNT_W-1:0] swr_cnt;
      logic                 irq_oe;
      logic                 primed;
      logic [2:0]           prev_ae;
      logic [2:0]           prev_re;
      logic [2:0]           prev_va;
      logic [2:0]           prev_ps;
      logic [2:0]           prev_qs;
      logic                 seq_armed;
      logic                 pin_s1;
      logic                 pin_s2;
   } miu_state_t;

   localparam logic [SWR_CNT_W-1:0] SWR_LAST = SWR_CNT_W'(SWR_CYCLES - 1);

   miu_state_t      s_r;
   miu_state_t      s_nxt;
   logic [19:0]     ev;
   logic [2:0]      sel;
   logic            ar_fire;
   logic            clr_rd;
   logic            sts_rd;
   logic            do_wr;
   logic            sw_start;
   logic [31:0]     wmerged;

   function automatic logic [31:0] miu_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[8*i +: 8] = new_v[8*i +: 8];
      end
      return r;
   endfunction : miu_merge

   assign s_axi_awready = !s_r.aw_have;
   assign s_axi_wready  = !s_r.w_have;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_bvalid  = s_r.bvalid;
   assign s_axi_bresp   = s_r.bresp;
   assign s_axi_rvalid  = s_r.rvalid;
   assign s_axi_rdata   = s_r.rdata;
   assign s_axi_rresp   = s_r.rresp;
   // open collector: the pin is only ever pulled low
   assign irq_n_o       = 1'b0;
   assign irq_n_oe      = s_r.irq_oe;

   always_comb
   begin
      s_nxt    = s_r;
      ev       = '0;
      sel      = s_r.comp[COMP_SEL_LSB +: 3];
      ar_fire  = s_axi_arvalid && !s_r.rvalid;
      clr_rd   = ar_fire && (s_axi_araddr[7:2] == IDX_CLR);
      sts_rd   = ar_fire && (s_axi_araddr[7:2] == IDX_FLAGS);
      do_wr    = s_r.aw_have && s_r.w_have && !s_r.bvalid;
      sw_start = 1'b0;
      wmerged  = '0;

      s_nxt.pin_s1  = irq_n_i;
      s_nxt.pin_s2  = s_r.pin_s1;
      s_nxt.primed  = 1'b1;
      s_nxt.prev_ae = active_energy_b14;
      s_nxt.prev_re = reactive_energy_b14;
      s_nxt.prev_va = apparent_energy_b15;
      s_nxt.prev_ps = active_power_sign;
      s_nxt.prev_qs = reactive_power_sign;

      // history is not valid in the first cycle, so no false edges at reset
      if (s_r.primed)
      begin
         ev[F_AE]  = |(active_energy_b14 ^ s_r.prev_ae);
         ev[F_RE]  = |(reactive_energy_b14 ^ s_r.prev_re);
         ev[F_VA]  = |(apparent_energy_b15 & ~s_r.prev_va);
         ev[F_APR] = |((active_power_sign ^ s_r.prev_ps) & sel);
         ev[F_RPR] = |((reactive_power_sign ^ s_r.prev_qs) & sel);
      end
      ev[F_SAG +: 3] = sag_event;
      ev[F_ZTO +: 3] = crossing_timeout_event;
      ev[F_ZX +: 3]  = crossing_event;
      ev[F_LC]       = line_cycle_done;
      ev[F_PKV]      = voltage_peak_exceeded;
      ev[F_PKI]      = current_peak_exceeded;
      ev[F_WF]       = waveform_sample_ready;

      // phase order: after an A crossing, the next crossing must be C
      if (crossing_event != 3'b000)
      begin
         ev[F_SEQ]       = s_r.seq_armed && crossing_event[1] && !crossing_event[2];
         s_nxt.seq_armed = crossing_event[0];
      end

      if (s_r.swr_busy)
      begin
         if (s_r.swr_cnt == SWR_LAST)
         begin
            s_nxt.swr_busy = 1'b0;
            ev[F_SWR]      = 1'b1;
         end
         else
            s_nxt.swr_cnt = s_r.swr_cnt + 1'b1;
      end

      // a set arriving with the clearing read wins over the clear
      s_nxt.flags = (clr_rd ? 20'h00000 : s_r.flags) | ev;

      if (s_axi_awvalid && !s_r.aw_have)
      begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_idx  = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !s_r.w_have)
      begin
         s_nxt.w_have = 1'b1;
         s_nxt.wdata  = s_axi_wdata;
         s_nxt.wstrb  = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready)
         s_nxt.bvalid = 1'b0;
      if (do_wr)
      begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = RESP_OKAY;
         unique case (s_r.aw_idx)
            IDX_MASK:
            begin
               wmerged    = miu_merge({12'h000, s_r.mask}, s_r.wdata, s_r.wstrb);
               s_nxt.mask = wmerged[19:0] & ~MASK_RSV;
            end
            IDX_COMP:
            begin
               wmerged    = miu_merge({24'h000000, s_r.comp}, s_r.wdata, s_r.wstrb);
               s_nxt.comp = wmerged[7:0];
            end
            IDX_OPM:
               sw_start = s_r.wstrb[0] && s_r.wdata[OPM_SWR_BIT];
            IDX_FLAGS, IDX_CLR:
               ;
            default:
               s_nxt.bresp = RESP_SLVERR;
         endcase
      end

      // software reset returns the registers to defaults, then bit 13 rises
      if (sw_start)
      begin
         s_nxt.mask     = '0;
         s_nxt.comp     = COMP_RST;
         s_nxt.flags    = '0;
         s_nxt.swr_busy = 1'b1;
         s_nxt.swr_cnt  = '0;
      end

      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;
      if (ar_fire)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            IDX_MASK:
               s_nxt.rdata = {12'h000, s_r.mask};
            IDX_FLAGS, IDX_CLR:
               s_nxt.rdata = {12'h000, s_r.flags};
            IDX_COMP:
               s_nxt.rdata = {24'h000000, s_r.comp};
            IDX_OPM:
               s_nxt.rdata = {24'h000000, s_r.pin_s2, s_r.swr_busy, 6'h00};
            default:
            begin
               s_nxt.rdata = 32'h00000000;
               s_nxt.rresp = RESP_SLVERR;
            end
         endcase
      end

      // the pin follows the flags in the same edge that updates them
      s_nxt.irq_oe = |(s_nxt.flags & s_nxt.mask);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_r       <= '0;
         s_r.flags <= FLAGS_RST;
         s_r.comp  <= COMP_RST;
      end
      else
         s_r <= s_nxt;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence clr_seq;
      clr_rd && (ev == 20'h00000);
   endsequence

   sequence sts_seq;
      sts_rd && !clr_rd;
   endsequence

   sequence steady_seq;
      !clr_rd && !sw_start;
   endsequence

   AST_IRQ_LOW: assert property (
      (|(s_r.flags & s_r.mask)) |-> irq_n_oe)
      else $error("enabled flag set but request not driven");

   AST_IRQ_RELEASE: assert property (
      clr_seq |=> !irq_n_oe && (s_r.flags == 20'h00000))
      else $error("clearing read did not release request");

   AST_STICKY: assert property (
      steady_seq |=> ((s_r.flags & $past(s_r.flags)) == $past(s_r.flags)))
      else $error("flag dropped without clearing read");

   AST_CLEAR_DATA: assert property (
      clr_seq |=> s_axi_rvalid && (s_axi_rdata[19:0] == $past(s_r.flags)))
      else $error("clearing read returned wrong flags");

   AST_AE_CHANGE: assert property (
      (s_r.primed && !sw_start && (active_energy_b14 != s_r.prev_ae)) |=> s_r.flags[F_AE])
      else $error("active energy half full not flagged");

   AST_VA_RISE: assert property (
      (s_r.primed && !sw_start && |(apparent_energy_b15 & ~s_r.prev_va)) |=> s_r.flags[F_VA])
      else $error("apparent energy rise not flagged");

   AST_SIGN_SEL: assert property (
      (s_r.primed && !sw_start && |((active_power_sign ^ s_r.prev_ps) & sel))
      |=> s_r.flags[F_APR])
      else $error("active sign reversal not flagged");

   AST_SEQ_ERR: assert property (
      (s_r.seq_armed && (crossing_event == 3'b010) && !sw_start) |=> s_r.flags[F_SEQ])
      else $error("phase order error not flagged");

   AST_SWR_DONE: assert property (
      (s_r.swr_busy && (s_r.swr_cnt == SWR_LAST) && !sw_start)
      |=> s_r.flags[F_SWR] && !s_r.swr_busy)
      else $error("reset done flag not set at end of wait");

   AST_SWR_START: assert property (
      sw_start |=> !s_r.flags[F_SWR] ##1 !s_r.flags[F_SWR])
      else $error("reset done flag set too early");

   AST_PLAIN_READ: assert property (
      (sts_seq and steady_seq) |=> s_axi_rvalid && (s_axi_rdata[19:0] == $past(s_r.flags))
      && (irq_n_oe == $past(irq_n_oe) || ($past(ev) != 20'h00000)))
      else $error("plain status read disturbed flags or request");

   AST_MASK_RSV: assert property (
      s_r.mask[F_SWR] == 1'b0)
      else $error("reserved mask bit set");

   AST_IRQ_IDLE: assert property (
      !(|(s_r.flags & s_r.mask)) |-> !irq_n_oe)
      else $error("request driven with no enabled flag set");

   AST_RE_CHANGE: assert property (
      (s_r.primed && !sw_start && (reactive_energy_b14 != s_r.prev_re)) |=> s_r.flags[F_RE])
      else $error("reactive energy half full not flagged");

   // pulses are checked against the pins, not against the internal event word
   AST_PULSE_SET: assert property (
      !sw_start |=> ((s_r.flags[12:3] & $past({line_cycle_done, crossing_event,
      crossing_timeout_event, sag_event})) == $past({line_cycle_done, crossing_event,
      crossing_timeout_event, sag_event})))
      else $error("pulse event not flagged");

   AST_PEAK_SET: assert property (
      !sw_start |=> ((s_r.flags[16:14] & $past({waveform_sample_ready, current_peak_exceeded,
      voltage_peak_exceeded})) == $past({waveform_sample_ready, current_peak_exceeded,
      voltage_peak_exceeded})))
      else $error("peak or sample event not flagged");

   AST_RSIGN_SEL: assert property (
      (s_r.primed && !sw_start && |((reactive_power_sign ^ s_r.prev_qs) & sel))
      |=> s_r.flags[F_RPR])
      else $error("reactive sign reversal not flagged");

   AST_SIGN_UNSEL: assert property (
      (s_r.primed && !s_r.flags[F_APR] && !(|((active_power_sign ^ s_r.prev_ps) & sel)))
      |=> !s_r.flags[F_APR])
      else $error("unselected phase raised sign reversal");

endmodule : miu_top

// File: miu_host.sv
// host model: AXI4-Lite master that services the interrupt unit
`timescale 1ns/1ps
module miu_host
   import miu_pkg::*;
(
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
   end

   // payload is scrambled once taken so a stale value cannot pass for a live one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (s_axi_wvalid && s_axi_wready)
            {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // service: plain status first to find the source, then the clearing read
   task automatic isr(output logic [31:0] f, output logic [31:0] c);
      logic [1:0] r;
      rd({IDX_FLAGS, 2'b00}, f, r);
      rd({IDX_CLR, 2'b00}, c, r);
   endtask : isr
endmodule : miu_host

// File: testbench.sv
// self-checking bench for the metering interrupt unit
`timescale 1ns/1ps
module testbench
   import miu_pkg::*;
;
   localparam logic [7:0] A_MSK = {IDX_MASK, 2'b00};
   localparam logic [7:0] A_FLG = {IDX_FLAGS, 2'b00};
   localparam logic [7:0] A_CLR = {IDX_CLR, 2'b00};
   localparam logic [7:0] A_CMP = {IDX_COMP, 2'b00};
   localparam logic [7:0] A_OPM = {IDX_OPM, 2'b00};
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, irq_n_i, irq_n_o, irq_n_oe;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, f, c;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [2:0]  active_energy_b14, reactive_energy_b14, apparent_energy_b15;
   logic [2:0]  active_power_sign, reactive_power_sign, sag_event;
   logic [2:0]  crossing_timeout_event, crossing_event;
   logic        line_cycle_done, voltage_peak_exceeded, current_peak_exceeded;
   logic        waveform_sample_ready;
   logic [19:0] ev;
   int          fails, checked;

   assign sag_event              = ev[5:3];
   assign crossing_timeout_event = ev[8:6];
   assign crossing_event         = ev[11:9];
   assign line_cycle_done        = ev[12];
   assign voltage_peak_exceeded  = ev[14];
   assign current_peak_exceeded  = ev[15];
   assign waveform_sample_ready  = ev[16];
   // pin has a pull-up; it is low only while the unit pulls it
   assign irq_n_i = irq_n_oe ? irq_n_o : 1'b1;

   miu_top #(.SWR_CYCLES(8)) uut (.*);
   miu_host host (.*);

   always #20 aclk = ~aclk;

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         fails++;
      end
   endtask : chk

   task automatic rdk(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] d;
      logic [1:0]  rr;
      host.rd(a, d, rr);
      chk(n, d, e);
   endtask : rdk

   // levels toggle phase A, apparent energy is set high; pulses last one cycle
   task automatic fire(input int i);
      @(posedge aclk);
      case (i)
         0: active_energy_b14[0] <= ~active_energy_b14[0];
         1: reactive_energy_b14[0] <= ~reactive_energy_b14[0];
         2: apparent_energy_b15[0] <= 1'b1;
         17: active_power_sign[0] <= ~active_power_sign[0];
         18: reactive_power_sign[0] <= ~reactive_power_sign[0];
         default: ev[i] <= 1'b1;
      endcase
      @(posedge aclk);
      ev <= 20'h00000;
   endtask : fire

   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic t_reset;
      rdk(A_FLG, 32'h00002000, "flags at reset");
      rdk(A_MSK, 32'h00000000, "mask at reset");
      rdk(A_CMP, 32'h0000001C, "comp at reset");
      rdk(A_CLR, 32'h00002000, "clearing read");
      rdk(A_FLG, 32'h00000000, "flags cleared");
      $display("test reset done");
   endtask : t_reset

   task automatic t_sel;
      host.wr(A_CMP, 32'h00000018, r);
      fire(17);
      fire(18);
      rdk(A_FLG, 32'h00000000, "unselected sign");
      host.wr(A_CMP, 32'h0000001C, r);
      $display("test phase select done");
   endtask : t_sel

   task automatic t_events;
      for (int i = 0; i < 19; i++)
      begin
         if (i inside {[9:11], 13})
            continue;
         fire(i);
         repeat (4) @(posedge aclk);
         host.isr(f, c);
         chk("flag", f, 32'h1 << i);
         chk("clr", c, 32'h1 << i);
         rdk(A_FLG, 32'h00000000, "after clear");
      end
      fire(9);
      fire(11);
      fire(10);
      host.isr(f, c);
      chk("crossings", f, 32'h00000E00);
      fire(9);
      fire(10);
      host.isr(f, c);
      chk("order error", f, 32'h00080600);
      $display("test events done");
   endtask : t_events

   task automatic t_irq;
      host.wr(A_MSK, 32'hFFFFFFFF, r);
      rdk(A_MSK, 32'h000FDFFF, "mask readback");
      host.wr(A_MSK, 32'h00000008, r);
      fire(4);
      #1 chk("masked event", irq_n_i, 1'b1);
      host.isr(f, c);
      fire(3);
      #1 chk("irq low", irq_n_i, 1'b0);
      repeat (6) @(posedge aclk);
      #1 chk("irq held", irq_n_i, 1'b0);
      rdk(A_OPM, 32'h00000000, "pin low");
      rdk(A_FLG, 32'h00000008, "plain read");
      #1 chk("irq after plain", irq_n_i, 1'b0);
      rdk(A_CLR, 32'h00000008, "clearing read");
      #1 chk("irq released", irq_n_i, 1'b1);
      $display("test irq done");
   endtask : t_irq

   task automatic t_swr;
      fire(3);
      host.wr(A_OPM, 32'h00000040, r);
      rdk(A_OPM, 32'h000000C0, "reset busy");
      rdk(A_FLG, 32'h00000000, "flags in reset");
      rdk(A_MSK, 32'h00000000, "mask in reset");
      repeat (12) @(posedge aclk);
      rdk(A_FLG, 32'h00002000, "reset done");
      rdk(A_FLG, 32'h00002000, "reset held");
      rdk(A_CLR, 32'h00002000, "reset clear");
      rdk(A_FLG, 32'h00000000, "reset cleared");
      rdk(A_OPM, 32'h00000080, "reset idle");
      host.rd(8'hFC, f, r);
      chk("unmapped resp", r, RESP_SLVERR);
      chk("unmapped data", f, 32'h00000000);
      host.wr(A_FLG, 32'h000FFFFF, r);
      chk("flag write resp", r, RESP_OKAY);
      rdk(A_FLG, 32'h00000000, "flag write");
      $display("test software reset done");
   endtask : t_swr

   // energy level inputs stay high across this reset, so a missing history guard shows up
   task automatic t_hwrst;
      host.wr(A_MSK, 32'h00000008, r);
      fire(3);
      #1 chk("irq before reset", irq_n_i, 1'b0);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      #1 chk("irq in reset", irq_n_i, 1'b1);
      rdk(A_FLG, 32'h00002000, "flags after reset");
      rdk(A_MSK, 32'h00000000, "mask after reset");
      $display("test mid reset done");
   endtask : t_hwrst

   initial
   begin
      {aclk, aresetn, ev, fails, checked} = '0;
      {active_energy_b14, reactive_energy_b14, apparent_energy_b15} = 9'h000;
      {active_power_sign, reactive_power_sign} = 6'h00;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_sel();
      t_events();
      t_irq();
      t_swr();
      t_hwrst();
      summarize();
   end

   // the tests need a few hundred cycles; this cuts a hang short
   initial
   begin
      repeat (20000) @(posedge aclk);
      fails++;
      summarize();
   end
endmodule : testbench
